//--- bench/ofd_decoder_sva.sv
// Concurrent checks on the opcode field decoder ports
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder_sva
  import ofd_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               clk_en,
  input wire logic [15:0]        ins_word,
  input wire ofd_pkg::ofd_kind_t ins_kind,
  input wire logic               ins_load,
  input wire logic               res_we,
  input wire logic [7:0]         res_data,
  input wire logic               mul_we,
  input wire logic [15:0]        mul_res,
  input wire logic [4:0]         reg_addr,
  input wire logic               reg_rd,
  input wire logic [20:0]        pc_now,
  input wire logic [7:0]         reg_rdata,
  input wire logic               second_word,
  input wire logic               word_nop,
  input wire logic [11:0]        data_addr,
  input wire logic               dest_acc,
  input wire logic               file_we,
  input wire logic [7:0]         file_wdata,
  input wire logic [2:0]         bit_idx,
  input wire logic [7:0]         bit_mask,
  input wire logic [11:0]        mv_src_addr,
  input wire logic [11:0]        mv_dst_addr,
  input wire logic               br_rel,
  input wire logic [20:0]        br_value,
  input wire logic [7:0]         product_high,
  input wire logic [7:0]         product_low,
  input wire logic [1:0]         phase,
  input wire logic               cycle_start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_pair_start;
    ins_load && clk_en && !second_word && !word_nop && ins_kind == KIND_MOVFF;
  endsequence
  sequence s_pair_second;
    second_word && mv_src_addr == $past(ins_word[11:0]) && mv_dst_addr == ins_word[11:0];
  endsequence
  property p_pair;
    s_pair_start |=> s_pair_second;
  endproperty
  property p_acc_bank;
    !second_word && !ins_word[8] |->
      data_addr == {(ins_word[7:0] < 8'h60) ? 4'h0 : 4'hF, ins_word[7:0]};
  endproperty
  property p_dest;
    !second_word && ins_kind == KIND_BYTE |-> dest_acc == !ins_word[9];
  endproperty
  property p_file_we;
    res_we && !second_word && ins_kind == KIND_BYTE && ins_word[9] && ins_word[15:12] != 4'hF
      |-> file_we && file_wdata == res_data;
  endproperty
  property p_bit;
    !second_word |-> bit_idx == ins_word[11:9] && bit_mask == (8'h01 << ins_word[11:9]);
  endproperty
  property p_lone;
    !second_word && ins_word[15:12] == 4'hF |-> word_nop && !file_we;
  endproperty
  property p_bra;
    !second_word && ins_kind == KIND_BRA |-> br_rel && br_value == {{10{ins_word[10]}}, ins_word[10:0]};
  endproperty
  property p_pcl;
    reg_rd && clk_en && reg_addr == REG_PCL |=> reg_rdata == $past(pc_now[7:0]);
  endproperty
  property p_mul;
    mul_we && clk_en |=> product_high == $past(mul_res[15:8]) && product_low == $past(mul_res[7:0]);
  endproperty
  property p_phase;
    cycle_start && clk_en |=> phase == PH_Q2 ##1 !clk_en || phase != PH_Q1;
  endproperty
  a_pair: assert property (p_pair) else $error("pair fields wrong");
  a_acc_bank: assert property (p_acc_bank) else $error("access bank wrong");
  a_dest: assert property (p_dest) else $error("dest select wrong");
  a_file_we: assert property (p_file_we) else $error("file write missing");
  a_bit: assert property (p_bit) else $error("bit select wrong");
  a_lone: assert property (p_lone) else $error("lone second word acts");
  a_bra: assert property (p_bra) else $error("branch offset wrong");
  a_pcl: assert property (p_pcl) else $error("pc low read wrong");
  a_mul: assert property (p_mul) else $error("product bytes wrong");
  a_phase: assert property (p_phase) else $error("phase step wrong");
endmodule // ofd_decoder_sva
bind ofd_decoder ofd_decoder_sva u_sva (.mclk, .rst_n, .clk_en, .ins_word, .ins_kind, .ins_load,
  .res_we, .res_data, .mul_we, .mul_res, .reg_addr, .reg_rd, .pc_now, .reg_rdata, .second_word,
  .word_nop, .data_addr, .dest_acc, .file_we, .file_wdata, .bit_idx, .bit_mask, .mv_src_addr,
  .mv_dst_addr, .br_rel, .br_value, .product_high, .product_low, .phase, .cycle_start);
`default_nettype wire

//--- bench/ofd_decoder_tb.sv
// Self-checking testbench for the opcode field decoder
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder_tb;
  import ofd_pkg::*;
  logic mclk, rst_n, clk_en, ins_load, res_we, flag_we, mul_we, tbl_exec, tbl_rd_we;
  logic call_exec, ret_exec, reg_wr, reg_rd, second_word, word_nop, access_ram;
  logic dest_acc, file_we, br_rel, cycle_start, fast_mode;
  ofd_tbl_t    tbl_mode;
  logic [15:0] ins_word, mul_res;
  logic [7:0]  res_data, tbl_rd_data, reg_wdata, reg_rdata, file_wdata, bit_mask, file_addr8;
  logic [7:0]  lit8, table_latch, working_accumulator, product_high, product_low;
  logic [4:0]  flag_in, reg_addr, alu_flags;
  logic [20:0] pc_now, br_value, tbl_addr, tp;
  logic [11:0] data_addr, mv_src_addr, mv_dst_addr, lit12;
  logic [19:0] lit20;
  logic [2:0]  bit_idx;
  logic [1:0]  ptr_sel, phase, p;
  ofd_kind_t   ins_kind;
  int          n_mismatch, check_count, n;
  ofd_decoder u_dut (.mclk, .rst_n, .clk_en, .ins_word, .ins_kind, .ins_load, .res_we, .res_data,
    .flag_we, .flag_in, .mul_we, .mul_res, .tbl_exec, .tbl_rd_we, .tbl_rd_data, .call_exec,
    .ret_exec, .pc_now, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .second_word,
    .word_nop, .access_ram, .data_addr, .dest_acc, .file_we, .file_wdata, .bit_idx, .bit_mask,
    .file_addr8, .ptr_sel, .mv_src_addr, .mv_dst_addr, .lit8, .lit12, .lit20, .br_rel, .br_value,
    .fast_mode, .tbl_mode, .tbl_addr, .table_latch, .working_accumulator, .alu_flags,
    .product_high, .product_low, .pc_high_latch(), .pc_upper_latch(), .phase, .cycle_start);
  always #12.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task cyc; @(posedge mclk); #1; endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; cyc; reg_wr <= 1'b0; cyc;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1; cyc; reg_rd <= 1'b0; chk("reg_rdata", e, reg_rdata); cyc;
  endtask
  // Decode settles combinationally, well before the next edge
  task set(input ofd_kind_t k, input logic [15:0] w);
    ins_kind <= k; ins_word <= w; #2;
  endtask
  task ld; ins_load <= 1'b1; cyc; ins_load <= 1'b0; #2; endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {mclk, rst_n, ins_load, res_we, flag_we, mul_we, tbl_exec, tbl_rd_we} = '0;
    {call_exec, ret_exec, reg_wr, reg_rd, clk_en} = 5'b00001;
    {ins_word, mul_res, res_data, tbl_rd_data, reg_wdata, flag_in, reg_addr} = '0;
    ins_kind = KIND_BYTE; pc_now = 21'h1A_BCDE; n_mismatch = 0; check_count = 0;
    repeat (12) cyc;
    rst_n <= 1'b1;
    for (int i = 0; i < 32; i++) if (i != 11 && i != 12) rd(i[4:0], 8'h00);
    rd(REG_PCL, 8'hDE);
    set(KIND_BYTE, 16'hF2AA); res_we <= 1'b1; #2;
    chk("word_nop", 1, word_nop); chk("file_we", 0, file_we); cyc; res_we <= 1'b0;
    chk("acc", 0, working_accumulator);
    set(KIND_BYTE, 16'h2634); res_data <= 8'h5A; res_we <= 1'b1; #2;
    chk("file_we", 1, file_we); chk("access_ram", 1, access_ram);
    chk("data_addr", 12'h034, data_addr); cyc; res_we <= 1'b0;
    set(KIND_BYTE, 16'h2480); res_we <= 1'b1; #2;
    chk("dest_acc", 1, dest_acc); chk("data_addr", 12'hF80, data_addr);
    cyc; res_we <= 1'b0; cyc; chk("acc", 8'h5A, working_accumulator);
    wr(REG_BSR, 8'hA5); rd(REG_BSR, 8'h05);
    set(KIND_BYTE, 16'h2534); chk("data_addr", 12'h534, data_addr);
    for (int b = 0; b < 8; b++)
    begin
      set(KIND_BIT, {4'h8, b[2:0], 9'h012});
      chk("bit_mask", 8'h01 << b, bit_mask); chk("file_addr8", 8'h12, file_addr8);
    end
    set(KIND_LIT, 16'h0E7F); chk("lit8", 8'h7F, lit8);
    set(KIND_MOVFF, 16'hC123); ld; ins_word <= 16'hF456; #2;
    chk("src", 12'h123, mv_src_addr); chk("dst", 12'h456, mv_dst_addr);
    chk("nop", 0, word_nop); ld; chk("second_word", 0, second_word);
    for (int j = 0; j < 2; j++)
    begin
      set(KIND_LFSR, j ? 16'hEEEA : 16'hEE2A); ld; ins_word <= 16'hF0BC; #2;
      chk("lit12", 12'hABC, lit12); chk("ptr_sel", 2, ptr_sel); ld;
    end
    set(KIND_GOTO, 16'hEF56); ld; ins_word <= 16'hF789; #2;
    chk("lit20", 20'h78956, lit20); chk("br_value", 21'h07_8956, br_value);
    chk("br_rel", 0, br_rel); ld;
    set(KIND_BRA, 16'hD400); chk("br_value", 21'h1F_FC00, br_value);
    set(KIND_BCC, 16'hE280); chk("br_value", 21'h1F_FF80, br_value);
    wr(5'h14, 8'h23); wr(5'h15, 8'h01);
    set(KIND_MOVSS, 16'hEB05); ld; ins_word <= 16'hF07F; #2;
    chk("src", 12'h128, mv_src_addr); chk("dst", 12'h1A2, mv_dst_addr); ld;
    rd(5'h14, 8'h23); rd(5'h18, 8'h00); rd(5'h1C, 8'h00);
    wr(REG_TPL, 8'hFF); wr(REG_TPH, 8'h10); wr(REG_TPU, 8'hFF); tp = 21'h1F_10FF;
    for (int m = 0; m < 4; m++)
    begin
      set(KIND_TBL, {14'h0, m[1:0]});
      chk("tbl_mode", m, tbl_mode);
      chk("tbl_addr", (m == 3) ? tp + 1 : tp, tbl_addr);
      tbl_exec <= 1'b1; cyc; tbl_exec <= 1'b0; cyc;
      tp = (m == 2) ? tp - 1 : (m == 0) ? tp : tp + 1;
    end
    rd(REG_TPL, tp[7:0]); rd(REG_TPH, tp[15:8]); rd(REG_TPU, {3'h0, tp[20:16]});
    tbl_rd_data <= 8'h3C; tbl_rd_we <= 1'b1; cyc; tbl_rd_we <= 1'b0; cyc;
    chk("latch", 8'h3C, table_latch); rd(REG_TLAT, 8'h3C);
    flag_in <= 5'h15; flag_we <= 1'b1; cyc; flag_we <= 1'b0; cyc;
    chk("flags", 5'h15, alu_flags); rd(REG_STAT, 8'h15);
    mul_res <= 16'hBEEF; mul_we <= 1'b1; cyc; mul_we <= 1'b0; cyc;
    chk("prod", 16'hBEEF, {product_high, product_low}); rd(REG_PRODUCT_HIGH, 8'hBE);
    wr(REG_PCLU, 8'hFF); rd(REG_PCLU, 8'h1F); wr(REG_PCLH, 8'h81); rd(REG_PCLH, 8'h81);
    wr(REG_ACC, 8'h11); set(KIND_CALL, 16'hEC01);
    chk("fast_mode", 1, fast_mode);
    call_exec <= 1'b1; cyc; call_exec <= 1'b0; wr(REG_ACC, 8'h22);
    set(KIND_RET, 16'h0012); chk("fast_mode", 0, fast_mode);
    ret_exec <= 1'b1; cyc; ret_exec <= 1'b0; cyc;
    rd(REG_ACC, 8'h22);
    set(KIND_RET, 16'h0013); ret_exec <= 1'b1; cyc; ret_exec <= 1'b0; cyc;
    rd(REG_ACC, 8'h11);
    n = 0;
    repeat (16)
    begin
      cyc; n += int'(cycle_start);
    end
    chk("cycles", 4, n);
    clk_en <= 1'b0; cyc; p = phase; repeat (3) cyc;
    chk("phase", p, phase); clk_en <= 1'b1; cyc;
    results;
  end
endmodule // ofd_decoder_tb
`default_nettype wire

//--- verilog/ofd_decoder.sv
// Instruction operand field decoder with its core registers
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder
  import ofd_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  input  wire logic [15:0]     ins_word,
  input  wire ofd_pkg::ofd_kind_t ins_kind,
  input  wire logic            ins_load,
  input  wire logic            res_we,
  input  wire logic [7:0]      res_data,
  input  wire logic            flag_we,
  input  wire logic [4:0]      flag_in,
  input  wire logic            mul_we,
  input  wire logic [15:0]     mul_res,
  input  wire logic            tbl_exec,
  input  wire logic            tbl_rd_we,
  input  wire logic [7:0]      tbl_rd_data,
  input  wire logic            call_exec,
  input  wire logic            ret_exec,
  input  wire logic [20:0]     pc_now,
  input  wire logic [ofd_pkg::AW-1:0] reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  output logic                 second_word,
  output logic                 word_nop,
  output logic                 access_ram,
  output logic [11:0]          data_addr,
  output logic                 dest_acc,
  output logic                 file_we,
  output logic [7:0]           file_wdata,
  output logic [2:0]           bit_idx,
  output logic [7:0]           bit_mask,
  output logic [7:0]           file_addr8,
  output logic [1:0]           ptr_sel,
  output logic [11:0]          mv_src_addr,
  output logic [11:0]          mv_dst_addr,
  output logic [7:0]           lit8,
  output logic [11:0]          lit12,
  output logic [19:0]          lit20,
  output logic                 br_rel,
  output logic [20:0]          br_value,
  output logic                 fast_mode,
  output ofd_pkg::ofd_tbl_t    tbl_mode,
  output logic [20:0]          tbl_addr,
  output logic [7:0]           table_latch,
  output logic [7:0]           working_accumulator,
  output logic [4:0]           alu_flags,
  output logic [7:0]           product_high,
  output logic [7:0]           product_low,
  output logic [7:0]           pc_high_latch,
  output logic [4:0]           pc_upper_latch,
  output logic [1:0]           phase,
  output logic                 cycle_start
);
  import ofd_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic two_word(input ofd_kind_t k);
    two_word = (k == KIND_MOVFF) || (k == KIND_LFSR) || (k == KIND_GOTO)
            || (k == KIND_CALL) || (k == KIND_MOVSF) || (k == KIND_MOVSS);
  endfunction

  function automatic logic [20:0] sext(input logic [10:0] v,
                                       input logic wide);
    sext = wide ? {{10{v[10]}}, v} : {{13{v[7]}}, v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]  acc_q;
  logic [3:0]  bsr_q;
  logic [4:0]  stat_q;
  logic [7:0]  product_low_q;
  logic [7:0]  product_high_q;
  logic [20:0] tptr_q;
  logic [7:0]  tlat_q;
  logic [7:0]  pclh_q;
  logic [4:0]  pclu_q;
  logic [11:0] ptr_q [NPTR];
  logic [7:0]  sh_acc_q;
  logic [3:0]  sh_bsr_q;
  logic [4:0]  sh_stat_q;
  logic        second_q;
  logic [15:0] first_q;
  ofd_kind_t   kind_q;
  ofd_phase_t  ph_q;
  ofd_phase_t  ph_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  ////////////////////////////////////////////////////////////////////
  // Field decode, all combinational

  logic [15:0] fw;
  ofd_kind_t   kind;
  logic [7:0]  fsel;
  logic        is_file;
  logic        rel_wide;

  // First word of a pair is replayed while its second word is on the bus
  assign fw          = second_q ? first_q : ins_word;
  assign kind        = second_q ? kind_q : ins_kind;
  assign second_word = second_q;
  // Lone tagged word outside a pair executes as nothing
  assign word_nop    = !second_q && (ins_word[15:12] == SECOND_TAG);

  assign fsel        = fw[7:0];
  assign is_file     = (kind == KIND_BYTE) || (kind == KIND_BIT);
  assign access_ram  = !fw[8];
  always_comb
  begin
    if (!fw[8])
      // Low part of access RAM in bank 0, upper part in top bank
      data_addr = {(fsel < ACC_SPLIT) ? ACC_LO_BNK : ACC_HI_BNK, fsel};
    else
      data_addr = {bsr_q, fsel};
  end

  assign dest_acc   = (kind == KIND_BYTE) && !fw[9];
  assign file_we    = res_we && is_file && !dest_acc && !word_nop;
  assign file_wdata = res_data;

  assign bit_idx    = fw[11:9];
  assign bit_mask   = 8'h01 << fw[11:9];

  assign file_addr8 = fsel;
  assign ptr_sel    = fw[5:4];

  logic [11:0] ofs_src;
  logic [11:0] ofs_dst;
  assign ofs_src = ptr_q[OFS_PTR] + {5'h00, fw[6:0]};
  assign ofs_dst = ptr_q[OFS_PTR] + {5'h00, ins_word[6:0]};

  always_comb
  begin
    case (kind)
      KIND_MOVSF,
      KIND_MOVSS: mv_src_addr = ofs_src;
      default:    mv_src_addr = fw[11:0];
    endcase
    case (kind)
      KIND_MOVSS: mv_dst_addr = ofs_dst;
      default:    mv_dst_addr = ins_word[11:0];
    endcase
  end

  assign lit8  = fw[7:0];
  assign lit12 = {fw[3:0], ins_word[7:0]};
  assign lit20 = {ins_word[11:0], fw[7:0]};

  assign br_rel   = (kind == KIND_BRA) || (kind == KIND_BCC);
  assign rel_wide = (kind == KIND_BRA);
  always_comb
  begin
    if (br_rel)
      br_value = sext(fw[10:0], rel_wide);
    else
      br_value = {1'b0, lit20};
  end

  // Only the documented field bits are looked at; others never steer
  assign fast_mode = fw[0];
  assign tbl_mode  = ofd_tbl_t'(fw[1:0]);
  assign tbl_addr  = (tbl_mode == TBL_PREINC) ? tptr_q + 21'h00_0001
                                              : tptr_q;

  ////////////////////////////////////////////////////////////////////
  // Word pairing

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      second_q <= 1'b0;
      first_q  <= RST_WORD;
      kind_q   <= KIND_BYTE;
    end
    else if (clk_en && ins_load)
    begin
      if (second_q)
        second_q <= 1'b0;
      else if (!word_nop)
      begin
        second_q <= two_word(ins_kind);
        first_q  <= ins_word;
        kind_q   <= ins_kind;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Instruction cycle phase

  always_comb
  begin
    case (ph_q)
      PH_Q1:   ph_d = PH_Q2;
      PH_Q2:   ph_d = PH_Q3;
      PH_Q3:   ph_d = PH_Q4;
      PH_Q4:   ph_d = PH_Q1;
      default: ph_d = PH_Q1;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ph_q <= PH_Q1;
    else if (clk_en)
      ph_q <= ph_d;
  end

  assign phase       = ph_q;
  assign cycle_start = (ph_q == PH_Q1);

  ////////////////////////////////////////////////////////////////////
  // Accumulator, bank select and flags, with fast shadows

  logic fast_call;
  logic fast_ret;
  assign fast_call = call_exec && fast_mode;
  assign fast_ret  = ret_exec && fast_mode;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sh_acc_q  <= RST_BYTE;
      sh_bsr_q  <= RST_BSR;
      sh_stat_q <= RST_STAT;
    end
    else if (clk_en && fast_call)
    begin
      sh_acc_q  <= acc_q;
      sh_bsr_q  <= bsr_q;
      sh_stat_q <= stat_q;
    end
  end

  // Restore beats a same-cycle result; hardware beats a register write
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      acc_q <= RST_BYTE;
    else if (clk_en)
    begin
      if (fast_ret)
        acc_q <= sh_acc_q;
      else if (res_we && dest_acc && !word_nop)
        acc_q <= res_data;
      else if (reg_wr && reg_addr == REG_ACC)
        acc_q <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      bsr_q <= RST_BSR;
    else if (clk_en)
    begin
      if (fast_ret)
        bsr_q <= sh_bsr_q;
      else if (reg_wr && reg_addr == REG_BSR)
        bsr_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      stat_q <= RST_STAT;
    else if (clk_en)
    begin
      if (fast_ret)
        stat_q <= sh_stat_q;
      else if (flag_we)
        stat_q <= flag_in;
      else if (reg_wr && reg_addr == REG_STAT)
        stat_q <= reg_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Product and program counter latches

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      product_low_q <= RST_BYTE;
      product_high_q <= RST_BYTE;
    end
    else if (clk_en)
    begin
      if (mul_we)
      begin
        product_high_q <= mul_res[15:8];
        product_low_q <= mul_res[7:0];
      end
      else if (reg_wr && reg_addr == REG_PRODUCT_LOW)
        product_low_q <= reg_wdata;
      else if (reg_wr && reg_addr == REG_PRODUCT_HIGH)
        product_high_q <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pclh_q <= RST_BYTE;
      pclu_q <= RST_STAT;
    end
    else if (clk_en && reg_wr)
    begin
      if (reg_addr == REG_PCLH)
        pclh_q <= reg_wdata;
      if (reg_addr == REG_PCLU)
        pclu_q <= reg_wdata[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Table pointer and latch

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tptr_q <= RST_TPTR;
    else if (clk_en)
    begin
      if (tbl_exec)
      begin
        case (tbl_mode)
          TBL_POSTINC,
          TBL_PREINC:  tptr_q <= tptr_q + 21'h00_0001;
          TBL_POSTDEC: tptr_q <= tptr_q - 21'h00_0001;
          default:     tptr_q <= tptr_q;
        endcase
      end
      else if (reg_wr && reg_addr == REG_TPL)
        tptr_q[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == REG_TPH)
        tptr_q[15:8] <= reg_wdata;
      else if (reg_wr && reg_addr == REG_TPU)
        tptr_q[20:16] <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tlat_q <= RST_BYTE;
    else if (clk_en)
    begin
      if (tbl_rd_we)
        tlat_q <= tbl_rd_data;
      else if (reg_wr && reg_addr == REG_TLAT)
        tlat_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Indirect pointers, two bytes each

  for (genvar i = 0; i < NPTR; i++)
  begin : g_ptr
    localparam logic [4:0] LO = REG_PTR0 + 5'(2 * i);
    localparam logic [4:0] HI = REG_PTR0 + 5'(2 * i + 1);
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        ptr_q[i] <= RST_PTR;
      else if (clk_en && reg_wr)
      begin
        if (reg_addr == LO)
          ptr_q[i][7:0] <= reg_wdata;
        else if (reg_addr == HI)
          ptr_q[i][11:8] <= reg_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register read port

  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      REG_ACC:   rdata_d = acc_q;
      REG_BSR:   rdata_d = {4'h0, bsr_q};
      REG_STAT:  rdata_d = {3'h0, stat_q};
      REG_PRODUCT_LOW: rdata_d = product_low_q;
      REG_PRODUCT_HIGH: rdata_d = product_high_q;
      REG_TPL:   rdata_d = tptr_q[7:0];
      REG_TPH:   rdata_d = tptr_q[15:8];
      REG_TPU:   rdata_d = {3'h0, tptr_q[20:16]};
      REG_TLAT:  rdata_d = tlat_q;
      REG_PCLH:  rdata_d = pclh_q;
      REG_PCLU:  rdata_d = {3'h0, pclu_q};
      REG_PCL:   rdata_d = pc_now[7:0];
      REG_CORE:  rdata_d = {5'h00, second_q, ph_q};
      default:
      begin
        // Only the pointer window reads back; higher offsets stay unmapped
        if (reg_addr >= REG_PTR0 && reg_addr < REG_PTR0 + 5'(2 * NPTR))
          rdata_d = reg_addr[0] ? {4'h0, ptr_q[reg_addr[2:1]][11:8]}
                                : ptr_q[reg_addr[2:1]][7:0];
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_q <= RST_BYTE;
    else if (clk_en)
      rdata_q <= reg_rd ? rdata_d : RST_BYTE;
  end

  assign reg_rdata           = rdata_q;
  assign table_latch         = tlat_q;
  assign working_accumulator = acc_q;
  assign alu_flags           = stat_q;
  assign product_high        = product_high_q;
  assign product_low         = product_low_q;
  assign pc_high_latch       = pclh_q;
  assign pc_upper_latch      = pclu_q;

endmodule // ofd_decoder
`default_nettype wire

//--- verilog/ofd_pkg.sv
// Constants, register map and types for the opcode field decoder
`default_nettype none
package ofd_pkg;
  // Register port
  localparam int unsigned AW = 5;
  localparam logic [4:0] REG_ACC   = 5'h00;
  localparam logic [4:0] REG_BSR   = 5'h01;
  localparam logic [4:0] REG_STAT  = 5'h02;
  localparam logic [4:0] REG_PRODUCT_LOW = 5'h03;
  localparam logic [4:0] REG_PRODUCT_HIGH = 5'h04;
  localparam logic [4:0] REG_TPL   = 5'h05;
  localparam logic [4:0] REG_TPH   = 5'h06;
  localparam logic [4:0] REG_TPU   = 5'h07;
  localparam logic [4:0] REG_TLAT  = 5'h08;
  localparam logic [4:0] REG_PCLH  = 5'h09;
  localparam logic [4:0] REG_PCLU  = 5'h0A;
  localparam logic [4:0] REG_PCL   = 5'h0B;
  localparam logic [4:0] REG_CORE  = 5'h0C;
  localparam logic [4:0] REG_PTR0  = 5'h10;
  // Status bit positions
  localparam int unsigned ST_C  = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z  = 2;
  localparam int unsigned ST_OV = 3;
  localparam int unsigned ST_N  = 4;
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [3:0]  RST_BSR  = 4'h0;
  localparam logic [4:0]  RST_STAT = 5'h00;
  localparam logic [20:0] RST_TPTR = 21'h00_0000;
  localparam logic [11:0] RST_PTR  = 12'h000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Field layout
  localparam logic [3:0] SECOND_TAG = 4'hF;
  localparam logic [7:0] ACC_SPLIT  = 8'h60;
  localparam logic [3:0] ACC_HI_BNK = 4'hF;
  localparam logic [3:0] ACC_LO_BNK = 4'h0;
  localparam int unsigned OFS_PTR   = 2;
  localparam int unsigned NPTR      = 4;
  // Cycles per instruction cycle
  localparam int unsigned OSC_PER_CYC = 4;

  typedef enum logic [3:0] {
    KIND_BYTE  = 4'h0,
    KIND_BIT   = 4'h1,
    KIND_LIT   = 4'h2,
    KIND_LFSR  = 4'h3,
    KIND_MOVFF = 4'h4,
    KIND_BRA   = 4'h5,
    KIND_BCC   = 4'h6,
    KIND_GOTO  = 4'h7,
    KIND_CALL  = 4'h8,
    KIND_RET   = 4'h9,
    KIND_TBL   = 4'hA,
    KIND_MOVSF = 4'hB,
    KIND_MOVSS = 4'hC
  } ofd_kind_t;

  typedef enum logic [1:0] {
    TBL_HOLD = 2'b00,
    TBL_POSTINC = 2'b01,
    TBL_POSTDEC = 2'b10,
    TBL_PREINC = 2'b11
  } ofd_tbl_t;

  // Gray sequence Q1 Q2 Q3 Q4
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } ofd_phase_t;
endpackage
`default_nettype wire
